/* File: hdl/fdim_top.sv */
// fieldbus drive input mapper: input variables to drive commands
// assumes all inputs synchronous to I_REF_CLK; each *_WR is a one-cycle update strobe
`timescale 1ns/10ps
`include "fdim_defines.svh"
module fdim_top #(
    parameter int unsigned DOUT_W = 64
) (
    input wire logic I_REF_CLK,
    input wire logic I_ARST_N,
    input wire logic [7:0] I_RUN_HALT_STATE,
    input wire logic [7:0] I_RUN_HALT_VALUE,
    input wire logic I_RUN_HALT_WR,
    input wire logic [15:0] I_DRIVE_COMMAND_WORD,
    input wire logic I_DRIVE_COMMAND_WORD_WR,
    input wire logic [7:0] I_FAULT_CLEAR_STATE,
    input wire logic I_FAULT_CLEAR_WR,
    input wire logic [15:0] I_PERCENT_SPEED,
    input wire logic I_PERCENT_SPEED_WR,
    input wire logic [15:0] I_HERTZ_SPEED,
    input wire logic I_HERTZ_SPEED_WR,
    input wire logic I_CLOSED_LOOP,
    input wire logic [15:0] I_LOOP_SETPOINT,
    input wire logic [1:0] I_LOOP_SETPOINT_IDX,
    input wire logic I_LOOP_SETPOINT_WR,
    input wire logic [15:0] I_BUS_FEEDBACK,
    input wire logic [1:0] I_BUS_FEEDBACK_IDX,
    input wire logic I_BUS_FEEDBACK_WR,
    input wire logic [DOUT_W-1:0] I_DISCRETE_OUTPUT_VECTOR,
    input wire logic I_DISCRETE_OUTPUT_WR,
    input wire logic [15:0] I_BASE_ANALOG_OUT_VALUE,
    input wire logic I_BASE_ANALOG_OUT_WR,
    input wire logic [7:0] I_BASE_ANALOG_OUT_SEL,
    input wire logic [15:0] I_BASE_ANALOG_TIMEOUT_LVL,
    input wire logic [15:0] I_OPTION_ANALOG_OUT_VALUE,
    input wire logic I_OPTION_ANALOG_OUT_WR,
    input wire logic [7:0] I_OPTION_ANALOG_OUT_SEL,
    input wire logic [15:0] I_OPTION_ANALOG_TIMEOUT_LVL,
    input wire logic I_BUS_TIMEOUT,
    output logic [15:0] O_COMMAND_WORD,
    output logic O_COMMAND_WORD_STB,
    output logic [15:0] O_SPEED_REF,
    output logic O_SPEED_REF_HZ,
    output logic O_SPEED_REF_AS_SETPOINT,
    output logic [15:0] O_LOOP_SETPOINT_0,
    output logic [15:0] O_LOOP_SETPOINT_1,
    output logic [15:0] O_LOOP_SETPOINT_2,
    output logic [15:0] O_BUS_FEEDBACK_0,
    output logic [15:0] O_BUS_FEEDBACK_1,
    output logic [15:0] O_BUS_FEEDBACK_2,
    output logic [1:0] O_BASE_DIGITAL_OUT,
    output logic [1:0] O_OPTION_DIGITAL_OUT,
    output logic [1:0] O_BASE_RELAY,
    output logic [2:0] O_OPTION_RELAY,
    output logic [15:0] O_BASE_ANALOG_LEVEL,
    output logic O_BASE_ANALOG_4_20,
    output logic O_BASE_ANALOG_BUS_CTRL,
    output logic O_BASE_ANALOG_TIMED_OUT,
    output logic [15:0] O_OPTION_ANALOG_LEVEL,
    output logic O_OPTION_ANALOG_4_20,
    output logic O_OPTION_ANALOG_BUS_CTRL,
    output logic O_OPTION_ANALOG_TIMED_OUT
);
    generate
        if (DOUT_W < `FDIM_DOUT_USED) begin : g_bad_dout
            $error("fdim_top: output vector narrower than mapped bits");
        end
    endgenerate

    fdim_pkg::fdim_sw_t run_sw;
    fdim_pkg::fdim_sw_t fault_sw;
    logic fault_go;
    logic [15:0] cmd_q;
    logic cmd_stb_q;
    logic [15:0] ref_q;
    logic ref_hz_q;
    logic ref_sp_q;
    logic [15:0] sp_q [3];
    logic [15:0] fb_q [3];
    logic [1:0] bdout_q;
    logic [1:0] odout_q;
    logic [1:0] brelay_q;
    logic [2:0] orelay_q;

    // run/halt value to reference in 0.005 percent units
    function automatic logic [15:0] run_ref(input logic [7:0] v);
        if (v > `FDIM_RUN_FULL_VAL) begin
            return `FDIM_REF_FULL;
        end
        return 16'({8'h00, v} * `FDIM_RUN_STEP);
    endfunction : run_ref

    // negative percent is cut to zero so direction never reverses
    function automatic logic [15:0] no_reverse(input logic [15:0] p);
        if (p[15]) begin
            return 16'h0000;
        end
        return p;
    endfunction : no_reverse

    assign run_sw = fdim_pkg::fdim_sw_decode(I_RUN_HALT_STATE);
    assign fault_sw = fdim_pkg::fdim_sw_decode(I_FAULT_CLEAR_STATE);
    assign fault_go = I_FAULT_CLEAR_WR && fault_sw == fdim_pkg::FDIM_SW_ON;

    // command word: fault clear, then raw word, then run/halt
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            cmd_q <= `FDIM_CMD_STOP;
            cmd_stb_q <= 1'b0;
        end else begin
            cmd_stb_q <= 1'b0;
            if (fault_go) begin
                cmd_q <= `FDIM_CMD_FAULT_RESET;
                cmd_stb_q <= 1'b1;
            end else if (I_DRIVE_COMMAND_WORD_WR) begin
                cmd_q <= I_DRIVE_COMMAND_WORD;
                cmd_stb_q <= 1'b1;
            end else if (I_RUN_HALT_WR) begin
                case (run_sw)
                    fdim_pkg::FDIM_SW_OFF: begin
                        cmd_q <= `FDIM_CMD_STOP;
                        cmd_stb_q <= 1'b1;
                    end
                    fdim_pkg::FDIM_SW_ON: begin
                        cmd_q <= `FDIM_CMD_RUN;
                        cmd_stb_q <= 1'b1;
                    end
                    default: begin
                        cmd_q <= cmd_q;
                    end
                endcase
            end
        end
    end

    // speed reference: last writer wins, one source expected
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ref_q <= 16'h0000;
            ref_hz_q <= 1'b0;
        end else if (I_PERCENT_SPEED_WR) begin
            ref_q <= no_reverse(I_PERCENT_SPEED);
            ref_hz_q <= 1'b0;
        end else if (I_HERTZ_SPEED_WR) begin
            ref_q <= I_HERTZ_SPEED;
            ref_hz_q <= 1'b1;
        end else if (I_RUN_HALT_WR && run_sw == fdim_pkg::FDIM_SW_ON) begin
            ref_q <= run_ref(I_RUN_HALT_VALUE);
            ref_hz_q <= 1'b0;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ref_sp_q <= 1'b0;
        end else begin
            ref_sp_q <= I_CLOSED_LOOP;
        end
    end

    // closed-loop setpoints and feedbacks, index 3 ignored
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            sp_q <= '{default: 16'h0000};
        end else if (I_LOOP_SETPOINT_WR && I_LOOP_SETPOINT_IDX != `FDIM_LOOP_CH) begin
            sp_q[I_LOOP_SETPOINT_IDX] <= I_LOOP_SETPOINT;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            fb_q <= '{default: 16'h0000};
        end else if (I_BUS_FEEDBACK_WR && I_BUS_FEEDBACK_IDX != `FDIM_LOOP_CH) begin
            fb_q[I_BUS_FEEDBACK_IDX] <= I_BUS_FEEDBACK;
        end
    end

    // discrete outputs; reserved bits are dropped
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            bdout_q <= 2'h0;
            odout_q <= 2'h0;
            brelay_q <= 2'h0;
            orelay_q <= 3'h0;
        end else if (I_DISCRETE_OUTPUT_WR) begin
            bdout_q <= I_DISCRETE_OUTPUT_VECTOR[`FDIM_BIT_BASE_DOUT +: 2];
            odout_q <= I_DISCRETE_OUTPUT_VECTOR[`FDIM_BIT_OPT_DOUT +: 2];
            brelay_q <= I_DISCRETE_OUTPUT_VECTOR[`FDIM_BIT_BASE_RELAY +: 2];
            orelay_q <= I_DISCRETE_OUTPUT_VECTOR[`FDIM_BIT_OPT_RELAY +: 3];
        end
    end

    fdim_aout #(.W(16)) u_base_aout (
        .i_clk(I_REF_CLK),
        .i_arst_n(I_ARST_N),
        .i_value(I_BASE_ANALOG_OUT_VALUE),
        .i_value_wr(I_BASE_ANALOG_OUT_WR),
        .i_sel(I_BASE_ANALOG_OUT_SEL),
        .i_timeout_lvl(I_BASE_ANALOG_TIMEOUT_LVL),
        .i_bus_timeout(I_BUS_TIMEOUT),
        .o_level(O_BASE_ANALOG_LEVEL),
        .o_range_4_20(O_BASE_ANALOG_4_20),
        .o_bus_ctrl(O_BASE_ANALOG_BUS_CTRL),
        .o_timed_out(O_BASE_ANALOG_TIMED_OUT)
    );

    fdim_aout #(.W(16)) u_option_aout (
        .i_clk(I_REF_CLK),
        .i_arst_n(I_ARST_N),
        .i_value(I_OPTION_ANALOG_OUT_VALUE),
        .i_value_wr(I_OPTION_ANALOG_OUT_WR),
        .i_sel(I_OPTION_ANALOG_OUT_SEL),
        .i_timeout_lvl(I_OPTION_ANALOG_TIMEOUT_LVL),
        .i_bus_timeout(I_BUS_TIMEOUT),
        .o_level(O_OPTION_ANALOG_LEVEL),
        .o_range_4_20(O_OPTION_ANALOG_4_20),
        .o_bus_ctrl(O_OPTION_ANALOG_BUS_CTRL),
        .o_timed_out(O_OPTION_ANALOG_TIMED_OUT)
    );

    assign O_COMMAND_WORD = cmd_q;
    assign O_COMMAND_WORD_STB = cmd_stb_q;
    assign O_SPEED_REF = ref_q;
    assign O_SPEED_REF_HZ = ref_hz_q;
    assign O_SPEED_REF_AS_SETPOINT = ref_sp_q;
    assign O_LOOP_SETPOINT_0 = sp_q[0];
    assign O_LOOP_SETPOINT_1 = sp_q[1];
    assign O_LOOP_SETPOINT_2 = sp_q[2];
    assign O_BUS_FEEDBACK_0 = fb_q[0];
    assign O_BUS_FEEDBACK_1 = fb_q[1];
    assign O_BUS_FEEDBACK_2 = fb_q[2];
    assign O_BASE_DIGITAL_OUT = bdout_q;
    assign O_OPTION_DIGITAL_OUT = odout_q;
    assign O_BASE_RELAY = brelay_q;
    assign O_OPTION_RELAY = orelay_q;

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_ARST_N);

    sequence s_run_only;
        I_RUN_HALT_WR && !fault_go && !I_DRIVE_COMMAND_WORD_WR;
    endsequence
    sequence s_ref_run_only;
        I_RUN_HALT_WR && !I_PERCENT_SPEED_WR && !I_HERTZ_SPEED_WR;
    endsequence

    a_stop_cmd: assert property (
        s_run_only and (I_RUN_HALT_STATE == `FDIM_SW_FALSE)
        |=> O_COMMAND_WORD == `FDIM_CMD_STOP && O_COMMAND_WORD_STB)
        else $error("stop command not issued");
    a_run_zero: assert property (
        s_ref_run_only and s_run_only and (run_sw == fdim_pkg::FDIM_SW_ON && I_RUN_HALT_VALUE == 8'h00)
        |=> O_COMMAND_WORD == `FDIM_CMD_RUN && O_SPEED_REF == 16'h0000)
        else $error("run at zero reference wrong");
    a_run_scaled: assert property (
        s_ref_run_only and (run_sw == fdim_pkg::FDIM_SW_ON && I_RUN_HALT_VALUE <= `FDIM_RUN_FULL_VAL)
        |=> O_SPEED_REF == 16'($past(I_RUN_HALT_VALUE) * `FDIM_RUN_STEP) && !O_SPEED_REF_HZ)
        else $error("run reference not scaled");
    a_run_full: assert property (
        s_ref_run_only and (run_sw == fdim_pkg::FDIM_SW_ON && I_RUN_HALT_VALUE > `FDIM_RUN_FULL_VAL)
        |=> O_SPEED_REF == `FDIM_REF_FULL)
        else $error("run reference not full scale");
    a_invalid_hold: assert property (
        s_run_only and (I_RUN_HALT_STATE == `FDIM_SW_DEFAULT)
        |=> $stable(O_COMMAND_WORD) && !O_COMMAND_WORD_STB)
        else $error("default state changed the command");
    a_raw_word: assert property (
        I_DRIVE_COMMAND_WORD_WR && !fault_go
        |=> O_COMMAND_WORD == $past(I_DRIVE_COMMAND_WORD) && O_COMMAND_WORD_STB)
        else $error("raw command word not applied");
    a_fault_reset: assert property (
        fault_go |=> O_COMMAND_WORD == `FDIM_CMD_FAULT_RESET && O_COMMAND_WORD[7])
        else $error("fault reset word not issued");
    a_no_reverse: assert property (
        !O_SPEED_REF_HZ |-> !O_SPEED_REF[15])
        else $error("percent reference negative");
    a_hz_ref: assert property (
        I_HERTZ_SPEED_WR && !I_PERCENT_SPEED_WR |=> O_SPEED_REF_HZ && O_SPEED_REF == $past(I_HERTZ_SPEED))
        else $error("hertz reference not applied");
    a_loop_mode: assert property (
        I_CLOSED_LOOP |=> O_SPEED_REF_AS_SETPOINT)
        else $error("closed loop not flagged");
    a_setpoint_two: assert property (
        I_LOOP_SETPOINT_WR && I_LOOP_SETPOINT_IDX == 2'h2 |=> O_LOOP_SETPOINT_2 == $past(I_LOOP_SETPOINT))
        else $error("setpoint not stored");
    a_feedback_zero: assert property (
        I_BUS_FEEDBACK_WR && I_BUS_FEEDBACK_IDX == 2'h0 |=> O_BUS_FEEDBACK_0 == $past(I_BUS_FEEDBACK))
        else $error("feedback not stored");
    a_relay_map: assert property (
        I_DISCRETE_OUTPUT_WR
        |=> O_OPTION_RELAY == $past(I_DISCRETE_OUTPUT_VECTOR[8:6])
        && O_BASE_DIGITAL_OUT == $past(I_DISCRETE_OUTPUT_VECTOR[1:0]))
        else $error("output vector misrouted");
endmodule : fdim_top

/* File: hdl/fdim_defines.svh */
// constants of the fieldbus drive input mapper
// assumes inclusion by bare name from the package and the design modules
`ifndef FDIM_DEFINES_SVH
`define FDIM_DEFINES_SVH

`define FDIM_SW_FALSE 8'h00
`define FDIM_SW_DEFAULT 8'hFF
`define FDIM_CMD_STOP 16'h043C
`define FDIM_CMD_RUN 16'h047C
`define FDIM_CMD_FAULT_RESET 16'h04BC
`define FDIM_RUN_FULL_VAL 8'hC8
`define FDIM_RUN_STEP 16'h0064
`define FDIM_REF_FULL 16'h4E20
`define FDIM_AOUT_MAX 16'h2710
`define FDIM_SEL_0_20 8'h8B
`define FDIM_SEL_4_20 8'h8C
`define FDIM_SEL_0_20_TO 8'h8D
`define FDIM_SEL_4_20_TO 8'h8E
`define FDIM_LOOP_CH 2'h3
`define FDIM_DOUT_USED 9
`define FDIM_BIT_BASE_DOUT 0
`define FDIM_BIT_OPT_DOUT 2
`define FDIM_BIT_BASE_RELAY 4
`define FDIM_BIT_OPT_RELAY 6

`endif

/* File: hdl/fdim_pkg.sv */
// types and decode helpers of the fieldbus drive input mapper
// assumes the defines header sits beside it
`include "fdim_defines.svh"
package fdim_pkg;

    typedef enum logic [2:0] {
        FDIM_SW_OFF = 3'h1,
        FDIM_SW_ON = 3'h2,
        FDIM_SW_INVALID = 3'h4
    } fdim_sw_t;

    typedef enum logic [2:0] {
        FDIM_AM_NONE = 3'h1,
        FDIM_AM_HOLD = 3'h2,
        FDIM_AM_FORCE = 3'h4
    } fdim_aout_mode_t;

    function automatic fdim_sw_t fdim_sw_decode(input logic [7:0] st);
        if (st == `FDIM_SW_DEFAULT) begin
            return FDIM_SW_INVALID;
        end else if (st == `FDIM_SW_FALSE) begin
            return FDIM_SW_OFF;
        end
        return FDIM_SW_ON;
    endfunction : fdim_sw_decode

endpackage : fdim_pkg

/* File: hdl/fdim_aout.sv */
// one bus-controlled analog output channel with timeout handling
// assumes the bus timeout is a single-cycle pulse on the same clock
`timescale 1ns/10ps
`include "fdim_defines.svh"
module fdim_aout #(
    parameter int unsigned W = 16
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [W-1:0] i_value,
    input wire logic i_value_wr,
    input wire logic [7:0] i_sel,
    input wire logic [W-1:0] i_timeout_lvl,
    input wire logic i_bus_timeout,
    output logic [W-1:0] o_level,
    output logic o_range_4_20,
    output logic o_bus_ctrl,
    output logic o_timed_out
);
    generate
        if (W < 14) begin : g_bad_w
            $error("fdim_aout: width too small for full scale");
        end
    endgenerate

    fdim_pkg::fdim_aout_mode_t mode;
    logic [W-1:0] level_q;
    logic range_q;
    logic ctrl_q;
    logic to_q;

    function automatic logic [W-1:0] clamp_lvl(input logic [W-1:0] v);
        if (v > W'(`FDIM_AOUT_MAX)) begin
            return W'(`FDIM_AOUT_MAX);
        end
        return v;
    endfunction : clamp_lvl

    always_comb begin
        case (i_sel)
            `FDIM_SEL_0_20, `FDIM_SEL_4_20: mode = fdim_pkg::FDIM_AM_HOLD;
            `FDIM_SEL_0_20_TO, `FDIM_SEL_4_20_TO: mode = fdim_pkg::FDIM_AM_FORCE;
            default: mode = fdim_pkg::FDIM_AM_NONE;
        endcase
    end

    // in the timeout-forcing selections a timeout wins over a write in the same cycle; in hold selections the write is taken
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            level_q <= '0;
            to_q <= 1'b0;
        end else if (i_bus_timeout && mode == fdim_pkg::FDIM_AM_FORCE) begin
            level_q <= clamp_lvl(i_timeout_lvl);
            to_q <= 1'b1;
        end else if (i_value_wr && mode != fdim_pkg::FDIM_AM_NONE) begin
            level_q <= clamp_lvl(i_value);
            to_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            range_q <= 1'b0;
            ctrl_q <= 1'b0;
        end else begin
            range_q <= (i_sel == `FDIM_SEL_4_20) || (i_sel == `FDIM_SEL_4_20_TO);
            ctrl_q <= (mode != fdim_pkg::FDIM_AM_NONE);
        end
    end

    assign o_level = level_q;
    assign o_range_4_20 = range_q;
    assign o_bus_ctrl = ctrl_q;
    assign o_timed_out = to_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    a_force_level: assert property (
        i_bus_timeout && mode == fdim_pkg::FDIM_AM_FORCE && i_timeout_lvl <= W'(`FDIM_AOUT_MAX)
        |=> o_level == $past(i_timeout_lvl) && o_timed_out)
        else $error("timeout level not forced");
    a_hold_level: assert property (
        i_bus_timeout && !i_value_wr && mode == fdim_pkg::FDIM_AM_HOLD |=> $stable(o_level))
        else $error("level moved on timeout in hold mode");
    a_write_gate: assert property (
        i_value_wr && mode == fdim_pkg::FDIM_AM_NONE && !i_bus_timeout |=> $stable(o_level))
        else $error("write taken without bus selection");
    a_level_span: assert property (o_level <= W'(`FDIM_AOUT_MAX))
        else $error("analog level above full scale");
    a_range_sel: assert property (
        (i_sel == `FDIM_SEL_0_20 || i_sel == `FDIM_SEL_0_20_TO) |=> !o_range_4_20 && o_bus_ctrl)
        else $error("wrong current range");
endmodule : fdim_aout

/* File: verif/fdim_net_ctrl.sv */
// network controller model: writes the mapper's input variables one at a time
// assumes the mapper samples on the rising edge of i_clk; drives on the falling edge
`timescale 1ns/10ps
module fdim_net_ctrl (
    input wire logic i_clk,
    output logic [15:0] o_word,
    output logic [7:0] o_state,
    output logic [7:0] o_value,
    output logic [63:0] o_vec,
    output logic [10:0] o_wr,
    output logic [7:0] o_sel_base,
    output logic [7:0] o_sel_opt,
    output logic [15:0] o_lvl,
    output logic o_closed_loop
);
    initial begin
        o_word = 16'h0000;
        o_state = 8'h00;
        o_value = 8'h00;
        o_vec = 64'h0000_0000_0000_0000;
        o_wr = 11'h000;
        o_sel_base = 8'h00;
        o_sel_opt = 8'h00;
        o_lvl = 16'h0000;
        o_closed_loop = 1'b0;
    end

    // one strobe per write, so references reach the drive on a single input
    task automatic wr(input int k, input logic [15:0] w, input logic [7:0] st, input logic [7:0] v);
        @(negedge i_clk);
        o_word = w;
        o_state = st;
        o_value = v;
        o_vec = {4{w}};
        o_wr = 11'h001 << k;
        @(negedge i_clk);
        o_wr = 11'h000;
        // stale data after the strobe must not be picked up again
        o_word = ~w;
        o_state = ~st;
        o_value = ~v;
        o_vec = {4{~w}};
    endtask : wr

    task automatic cfg(input logic [7:0] sb, input logic [7:0] so, input logic [15:0] l, input logic cl);
        @(negedge i_clk);
        o_sel_base = sb;
        o_sel_opt = so;
        o_lvl = l;
        o_closed_loop = cl;
    endtask : cfg
endmodule : fdim_net_ctrl

/* File: verif/test_fdim_top.sv */
// self-checking bench of the fieldbus drive input mapper
// assumes the network controller model drives every mapper input except clock and reset
`timescale 1ns/10ps
module test_fdim_top;
    typedef struct {
        int k;
        logic [15:0] w;
        logic [7:0] st;
        logic [7:0] v;
        logic [15:0] cmd;
        logic stb;
        logic [15:0] rf;
        logic hz;
    } fdim_row_t;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] word, lvl, cmd, rf, sp0, sp1, sp2, fb0, fb1, fb2, bl, ol;
    logic [7:0] state, value, selb, selo;
    logic [63:0] vec;
    logic [10:0] wr;
    logic cl, stb, hz, as_sp, b420, bbc, bto, o420, obc, oto;
    logic [1:0] bdo, odo, brl;
    logic [2:0] orl;
    int num_errors = 0;
    int n_compared = 0;
    fdim_row_t rows [17];

    always #10 clk = ~clk;

    fdim_net_ctrl i_fdim_net_ctrl (.i_clk(clk), .o_word(word), .o_state(state), .o_value(value), .o_vec(vec),
        .o_wr(wr), .o_sel_base(selb), .o_sel_opt(selo), .o_lvl(lvl), .o_closed_loop(cl));

    fdim_top i_fdim_top (.I_REF_CLK(clk), .I_ARST_N(arst_n), .I_RUN_HALT_STATE(state), .I_RUN_HALT_VALUE(value),
        .I_RUN_HALT_WR(wr[0]), .I_DRIVE_COMMAND_WORD(word), .I_DRIVE_COMMAND_WORD_WR(wr[1]),
        .I_FAULT_CLEAR_STATE(state), .I_FAULT_CLEAR_WR(wr[2]), .I_PERCENT_SPEED(word), .I_PERCENT_SPEED_WR(wr[3]),
        .I_HERTZ_SPEED(word), .I_HERTZ_SPEED_WR(wr[4]), .I_CLOSED_LOOP(cl), .I_LOOP_SETPOINT(word),
        .I_LOOP_SETPOINT_IDX(value[1:0]), .I_LOOP_SETPOINT_WR(wr[5]), .I_BUS_FEEDBACK(word),
        .I_BUS_FEEDBACK_IDX(value[1:0]), .I_BUS_FEEDBACK_WR(wr[6]), .I_DISCRETE_OUTPUT_VECTOR(vec),
        .I_DISCRETE_OUTPUT_WR(wr[7]), .I_BASE_ANALOG_OUT_VALUE(word), .I_BASE_ANALOG_OUT_WR(wr[8]),
        .I_BASE_ANALOG_OUT_SEL(selb), .I_BASE_ANALOG_TIMEOUT_LVL(lvl), .I_OPTION_ANALOG_OUT_VALUE(word),
        .I_OPTION_ANALOG_OUT_WR(wr[9]), .I_OPTION_ANALOG_OUT_SEL(selo), .I_OPTION_ANALOG_TIMEOUT_LVL(lvl),
        .I_BUS_TIMEOUT(wr[10]), .O_COMMAND_WORD(cmd), .O_COMMAND_WORD_STB(stb), .O_SPEED_REF(rf),
        .O_SPEED_REF_HZ(hz), .O_SPEED_REF_AS_SETPOINT(as_sp), .O_LOOP_SETPOINT_0(sp0), .O_LOOP_SETPOINT_1(sp1),
        .O_LOOP_SETPOINT_2(sp2), .O_BUS_FEEDBACK_0(fb0), .O_BUS_FEEDBACK_1(fb1), .O_BUS_FEEDBACK_2(fb2),
        .O_BASE_DIGITAL_OUT(bdo), .O_OPTION_DIGITAL_OUT(odo), .O_BASE_RELAY(brl), .O_OPTION_RELAY(orl),
        .O_BASE_ANALOG_LEVEL(bl), .O_BASE_ANALOG_4_20(b420), .O_BASE_ANALOG_BUS_CTRL(bbc),
        .O_BASE_ANALOG_TIMED_OUT(bto), .O_OPTION_ANALOG_LEVEL(ol), .O_OPTION_ANALOG_4_20(o420),
        .O_OPTION_ANALOG_BUS_CTRL(obc), .O_OPTION_ANALOG_TIMED_OUT(oto));

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp16

    task automatic cmp1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp1

    task automatic test_done();
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        test_done();
    end

    initial begin
        rows = '{'{0, 16'h0000, 8'h00, 8'h37, 16'h043C, 1'b1, 16'h0000, 1'b0},
            '{0, 16'h0000, 8'h01, 8'h00, 16'h047C, 1'b1, 16'h0000, 1'b0},
            '{0, 16'h0000, 8'h01, 8'h01, 16'h047C, 1'b1, 16'h0064, 1'b0},
            '{0, 16'h0000, 8'h5A, 8'hC8, 16'h047C, 1'b1, 16'h4E20, 1'b0},
            '{0, 16'h0000, 8'h01, 8'hC9, 16'h047C, 1'b1, 16'h4E20, 1'b0},
            '{0, 16'h0000, 8'h01, 8'h64, 16'h047C, 1'b1, 16'h2710, 1'b0},
            '{0, 16'h0000, 8'hFF, 8'h02, 16'h047C, 1'b0, 16'h2710, 1'b0},
            '{0, 16'h0000, 8'h01, 8'hFF, 16'h047C, 1'b1, 16'h4E20, 1'b0},
            '{1, 16'h1234, 8'h00, 8'h00, 16'h1234, 1'b1, 16'h4E20, 1'b0},
            '{2, 16'h0000, 8'h01, 8'h00, 16'h04BC, 1'b1, 16'h4E20, 1'b0},
            '{2, 16'h0000, 8'h00, 8'h00, 16'h04BC, 1'b0, 16'h4E20, 1'b0},
            '{2, 16'h0000, 8'hFF, 8'h00, 16'h04BC, 1'b0, 16'h4E20, 1'b0},
            '{3, 16'h1000, 8'h00, 8'h00, 16'h04BC, 1'b0, 16'h1000, 1'b0},
            '{3, 16'hFFF0, 8'h00, 8'h00, 16'h04BC, 1'b0, 16'h0000, 1'b0},
            '{3, 16'h7FFE, 8'h00, 8'h00, 16'h04BC, 1'b0, 16'h7FFE, 1'b0},
            '{4, 16'hFFFF, 8'h00, 8'h00, 16'h04BC, 1'b0, 16'hFFFF, 1'b1},
            '{0, 16'h0000, 8'h01, 8'h02, 16'h047C, 1'b1, 16'h00C8, 1'b0}};
        repeat (5) @(posedge clk);
        cmp16(cmd, 16'h043C);
        cmp16(rf, 16'h0000);
        cmp1(stb, 1'b0);
        @(negedge clk);
        arst_n = 1'b1;
        for (int i = 0; i < 17; i++) begin
            i_fdim_net_ctrl.wr(rows[i].k, rows[i].w, rows[i].st, rows[i].v);
            cmp16(cmd, rows[i].cmd);
            cmp1(stb, rows[i].stb);
            cmp16(rf, rows[i].rf);
            cmp1(hz, rows[i].hz);
        end
        // index 3 is written last and must leave every channel alone
        for (int i = 0; i < 4; i++) begin
            i_fdim_net_ctrl.wr(5, 16'h8000 | 16'(i), 8'h00, 8'(i));
            i_fdim_net_ctrl.wr(6, 16'hC000 | 16'(i), 8'h00, 8'(i));
        end
        cmp16(sp0, 16'h8000);
        cmp16(sp1, 16'h8001);
        cmp16(sp2, 16'h8002);
        cmp16(fb0, 16'hC000);
        cmp16(fb1, 16'hC001);
        cmp16(fb2, 16'hC002);
        i_fdim_net_ctrl.wr(7, 16'h0155, 8'h00, 8'h00);
        cmp16(16'({orl, brl, odo, bdo}), 16'h0155);
        i_fdim_net_ctrl.wr(7, 16'hFEAA, 8'h00, 8'h00);
        cmp16(16'({orl, brl, odo, bdo}), 16'h00AA);
        for (int s = 139; s < 143; s++) begin
            i_fdim_net_ctrl.cfg(8'(s), 8'(s), 16'h00C8, 1'b1);
            i_fdim_net_ctrl.wr(8, 16'h1388, 8'h00, 8'h00);
            i_fdim_net_ctrl.wr(9, 16'h2EE0, 8'h00, 8'h00);
            cmp16(bl, 16'h1388);
            cmp16(ol, 16'h2710);
            cmp1(b420, ~s[0]);
            cmp1(o420, ~s[0]);
            cmp1(bbc, 1'b1);
            cmp1(obc, 1'b1);
            cmp1(bto, 1'b0);
            cmp1(oto, 1'b0);
            i_fdim_net_ctrl.wr(10, 16'h0000, 8'h00, 8'h00);
            cmp16(bl, (s > 140) ? 16'h00C8 : 16'h1388);
            cmp16(ol, (s > 140) ? 16'h00C8 : 16'h2710);
            cmp1(bto, s > 140);
            cmp1(oto, s > 140);
        end
        cmp1(as_sp, 1'b1);
        i_fdim_net_ctrl.cfg(8'h10, 8'h10, 16'h00C8, 1'b0);
        i_fdim_net_ctrl.wr(8, 16'h0BB8, 8'h00, 8'h00);
        cmp16(bl, 16'h00C8);
        cmp1(bbc, 1'b0);
        cmp1(as_sp, 1'b0);
        // second reset in mid-run
        arst_n = 1'b0;
        #1;
        cmp16(cmd, 16'h043C);
        cmp16(bl, 16'h0000);
        cmp16(16'({orl, brl, odo, bdo}), 16'h0000);
        @(negedge clk);
        arst_n = 1'b1;
        i_fdim_net_ctrl.wr(0, 16'h0000, 8'h01, 8'h64);
        cmp16(cmd, 16'h047C);
        cmp16(rf, 16'h2710);
        test_done();
    end
endmodule : test_fdim_top
